// >>> inc/edc_pkg.sv
// Constants and types shared by the energy detect and assessment unit
package edc_pkg;

    // Register addresses on the byte register port
    localparam logic [5:0] ADDR_STATUS = 6'h01;
    localparam logic [5:0] ADDR_LEVEL  = 6'h07;
    localparam logic [5:0] ADDR_CCA    = 6'h08;
    localparam logic [5:0] ADDR_THRES  = 6'h09;

    // Field positions
    localparam int REQ_BIT  = 7;
    localparam int MODE_LSB = 5;
    localparam int THR_W    = 4;

    // Reset and limit values
    localparam logic [7:0]       LEVEL_RESET = 8'hFF;
    localparam logic [7:0]       LEVEL_MAX   = 8'h53;
    localparam logic [1:0]       MODE_RESET  = 2'h1;
    localparam logic [THR_W-1:0] THR_RESET   = 4'h7;

    // Timing, in ns, and derived cycle counts at 20 MHz
    localparam int CLK_PERIOD_NS = 50;
    localparam int T_RSSI_NS     = 2000;
    localparam int T_ED_LONG_NS  = 128000;
    localparam int T_ED_SHORT_NS = 32000;
    localparam int T_CCA_MAX_NS  = 180000;
    localparam int SAMPLE_CYC    = T_RSSI_NS / CLK_PERIOD_NS;
    localparam int LONG_SAMPLES  = T_ED_LONG_NS / T_RSSI_NS;
    localparam int SHORT_SAMPLES = T_ED_SHORT_NS / T_RSSI_NS;
    localparam int ED_LONG_CYC   = LONG_SAMPLES * SAMPLE_CYC;
    localparam int CCA_MAX_CYC   = T_CCA_MAX_NS / CLK_PERIOD_NS;

    // Assessment methods
    typedef enum logic [1:0] {
        M_CS_OR   = 2'h0,
        M_ENERGY  = 2'h1,
        M_CS_ONLY = 2'h2,
        M_CS_AND  = 2'h3
    } edc_method_type;

    // Sequencer states, one-hot
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_ED   = 5'h02,
        ST_CCA  = 5'h04,
        ST_WAIT = 5'h08,
        ST_FIN  = 5'h10
    } edc_state_type;

endpackage : edc_pkg

// >>> inc/edc_meas_if.sv
// Link between the sequencer and the energy averager
`timescale 1ns/1ps
`default_nettype none
interface edc_meas_if;
    logic       start;
    logic       long_win;
    logic       busy;
    logic       done;
    logic [7:0] level;
    modport ctl (output start, output long_win,
                 input busy, input done, input level);
    modport avg (input start, input long_win,
                 output busy, output done, output level);
endinterface : edc_meas_if
`default_nettype wire

// >>> hw/edc_energy_avg.sv
// Energy averager: sums power samples over a window, scales to 1 dB
`timescale 1ns/1ps
`default_nettype none
module edc_energy_avg
#(
    parameter int SAMPLE_CYC = edc_pkg::SAMPLE_CYC,
    parameter int LONG_N     = edc_pkg::LONG_SAMPLES,
    parameter int SHORT_N    = edc_pkg::SHORT_SAMPLES
)
(
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    // Power samples from the receive path, 3 dB steps
    input  wire logic [4:0] rssi,
    // Control link
    edc_meas_if.avg         m
);
    import edc_pkg::*;

    localparam int TW = $clog2(SAMPLE_CYC + 1);
    localparam int NW = $clog2(LONG_N + 1);
    localparam int LSH = $clog2(LONG_N);
    localparam int SSH = $clog2(SHORT_N);

    // Refuse windows the shift scaling or the 16-bit sum cannot serve
    if (SAMPLE_CYC < 1 || (LONG_N & (LONG_N - 1)) != 0 ||
        (SHORT_N & (SHORT_N - 1)) != 0 || SHORT_N > LONG_N ||
        LONG_N < 2 || SHORT_N < 1 || LONG_N > 2048)
        $error("edc_energy_avg: bad window parameters");

    logic [TW-1:0] tick;
    logic [NW-1:0] left;
    logic [15:0]   acc;
    logic          long_q;

    // Sample strobe and window arithmetic
    wire        sample   = m.busy && tick == '0;
    wire        last     = sample && left == NW'(1);
    wire [15:0] acc_nx   = acc + {11'h000, rssi};
    wire [17:0] scaled   = {2'h0, acc_nx} * 18'h00003;
    wire [17:0] avg      = long_q ? (scaled >> LSH) : (scaled >> SSH);
    wire [7:0]  clamped  = (avg > {10'h000, LEVEL_MAX}) ? LEVEL_MAX
                                                        : avg[7:0];

    // Window counting and accumulation
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            m.busy  <= 1'b0;
            m.done  <= 1'b0;
            m.level <= 8'h00;
            tick    <= '0;
            left    <= '0;
            acc     <= 16'h0000;
            long_q  <= 1'b1;
        end
        else
        begin
            m.done <= 1'b0;
            if (m.start && !m.busy)
            begin
                m.busy <= 1'b1;
                long_q <= m.long_win;
                tick   <= TW'(SAMPLE_CYC - 1);
                left   <= m.long_win ? NW'(LONG_N) : NW'(SHORT_N);
                acc    <= 16'h0000;
            end
            else if (m.busy)
            begin
                tick <= sample ? TW'(SAMPLE_CYC - 1) : tick - TW'(1);
                if (sample)
                begin
                    acc  <= acc_nx;
                    left <= left - NW'(1);
                end
                if (last)
                begin
                    m.busy  <= 1'b0;
                    m.done  <= 1'b1;
                    m.level <= clamped;
                end
            end
        end
    end

endmodule : edc_energy_avg
`default_nettype wire

// >>> hw/edc_energy_detect_cca.sv
// Energy detection result and clear channel assessment sequencer
`timescale 1ns/1ps
`default_nettype none
module edc_energy_detect_cca
(
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  resetn,
    // Register write port
    input  wire logic                  reg_wr,
    input  wire logic [5:0]            reg_addr,
    input  wire logic [7:0]            reg_wdata,
    // Receive path indications
    input  wire logic                  rx_listen,
    input  wire logic                  rx_busy,
    input  wire logic                  basic_mode,
    input  wire logic                  high_rate,
    input  wire logic                  shr_detect,
    input  wire logic                  carrier_sense,
    input  wire logic [4:0]            rssi,
    // Register contents and status
    output var  logic [7:0]            energy_level_field,
    output var  logic                  assess_complete_flag,
    output var  logic                  channel_idle_flag,
    output var  edc_pkg::edc_method_type assess_method_select,
    output var  logic [edc_pkg::THR_W-1:0] energy_threshold_field,
    // Shared completion event
    output var  logic                  measure_done_event
);
    import edc_pkg::*;

    edc_meas_if m ();

    edc_energy_avg u_avg
    (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .rssi    (rssi),
        .m       (m.avg)
    );

    edc_state_type state;
    edc_state_type next_state;
    logic          auto_used;
    logic          auto_run;
    logic          cs_seen;
    logic          no_meas;
    logic [7:0]    eval_level;

    // Register decode
    wire wr_level = reg_wr && reg_addr == ADDR_LEVEL;
    wire wr_cca   = reg_wr && reg_addr == ADDR_CCA;
    wire wr_thr   = reg_wr && reg_addr == ADDR_THRES;
    wire cca_req  = wr_cca && reg_wdata[REQ_BIT];
    wire in_rx    = rx_listen || rx_busy;
    wire cca_ok   = basic_mode && in_rx;
    wire idle_st  = state == ST_IDLE;

    // Automatic start: first preamble of a frame only
    wire auto_go = shr_detect && !auto_used && !m.busy;

    // Manual energy measurement only in listen state
    wire ed_go = idle_st && wr_level && rx_listen && !m.busy && !auto_go;
    // Energy request that cannot measure still reports
    wire ed_nop = idle_st && wr_level && !ed_go;

    // Assessment request routing on the method written with it
    wire [1:0] req_method  = reg_wdata[MODE_LSB+1:MODE_LSB];
    wire       energy_mode = req_method != M_CS_ONLY;
    wire cca_listen  = idle_st && cca_req && cca_ok && rx_listen &&
                       !m.busy && !auto_go;
    wire cca_wait    = idle_st && cca_req && cca_ok && !cca_listen &&
                       energy_mode && (auto_run || auto_go || m.busy);
    wire cca_now     = idle_st && cca_req && !cca_listen && !cca_wait;

    // Averager start; auto window shortens at high rate
    assign m.start    = auto_go || ed_go || cca_listen;
    assign m.long_win = auto_go ? !high_rate : 1'b1;

    // Busy evaluation per method; 2 dB per threshold step
    wire [7:0] thr_db   = {3'h0, energy_threshold_field, 1'b0};
    wire       e_busy   = eval_level != LEVEL_RESET && eval_level > thr_db;
    logic      ch_busy;
    always_comb
    begin
        case (assess_method_select)
            M_ENERGY:  ch_busy = e_busy;
            M_CS_ONLY: ch_busy = cs_seen;
            M_CS_OR:   ch_busy = cs_seen || e_busy;
            M_CS_AND:  ch_busy = cs_seen && e_busy;
            default:   ch_busy = 1'b1;
        endcase
    end

    // Sequencer next state
    always_comb
    begin
        case (state)
            ST_IDLE:
                if (cca_listen)
                    next_state = ST_CCA;
                else if (cca_wait)
                    next_state = ST_WAIT;
                else if (cca_now)
                    next_state = ST_FIN;
                else if (ed_go)
                    next_state = ST_ED;
                else
                    next_state = ST_IDLE;
            ST_ED:   next_state = m.done ? ST_IDLE : ST_ED;
            ST_CCA:  next_state = m.done ? ST_FIN : ST_CCA;
            ST_WAIT: next_state = m.busy ? ST_WAIT : ST_FIN;
            ST_FIN:  next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            state <= ST_IDLE;
        else
            state <= next_state;
    end

    // Frame bookkeeping for the automatic measurement
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            auto_used <= 1'b0;
            auto_run  <= 1'b0;
        end
        else
        begin
            if (shr_detect)
                auto_used <= 1'b1;
            else if (!rx_busy)
                auto_used <= 1'b0;
            if (auto_go)
                auto_run <= 1'b1;
            else if (m.done)
                auto_run <= 1'b0;
        end
    end

    // Energy level result; reset marks no measurement yet
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            energy_level_field <= LEVEL_RESET;
        else if (m.done && (auto_run || state == ST_ED))
            energy_level_field <= m.level;
    end

    // Assessment evidence: carrier seen and level to judge
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cs_seen    <= 1'b0;
            no_meas    <= 1'b0;
            eval_level <= LEVEL_RESET;
        end
        else
        begin
            if (cca_req && idle_st)
            begin
                cs_seen <= carrier_sense;
                no_meas <= !cca_ok;
            end
            else if (state != ST_IDLE)
                cs_seen <= cs_seen || carrier_sense;
            if (m.done)
                eval_level <= m.level;
            else if (cca_now)
                eval_level <= energy_level_field;
        end
    end

    // Flags: a finish in the request cycle wins over the clear
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            assess_complete_flag <= 1'b0;
            channel_idle_flag    <= 1'b0;
        end
        else if (state == ST_FIN)
        begin
            assess_complete_flag <= 1'b1;
            channel_idle_flag    <= !no_meas && !ch_busy;
        end
        else if (cca_req)
        begin
            assess_complete_flag <= 1'b0;
            channel_idle_flag    <= 1'b0;
        end
    end

    // Done event pulse for energy and assessment ends
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            measure_done_event <= 1'b0;
        else
            measure_done_event <= state == ST_FIN ||
                                  (state == ST_ED && m.done) ||
                                  ed_nop;
    end

    // Configuration registers
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            assess_method_select   <= edc_method_type'(MODE_RESET);
            energy_threshold_field <= THR_RESET;
        end
        else
        begin
            if (wr_cca)
                assess_method_select <=
                    edc_method_type'(reg_wdata[MODE_LSB+1:MODE_LSB]);
            if (wr_thr)
                energy_threshold_field <= reg_wdata[THR_W-1:0];
        end
    end

    // Helper counters for the timing checks
    logic [11:0] ed_cyc;
    logic [11:0] cca_age;
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ed_cyc  <= 12'h000;
            cca_age <= 12'h000;
        end
        else
        begin
            ed_cyc  <= (state == ST_ED) ? ed_cyc + 12'h001 : 12'h000;
            cca_age <= (idle_st || state == ST_ED) ? 12'h000
                                                    : cca_age + 12'h001;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    // Result stays in range or at the no-result marker
    a_level_range: assert property (
        energy_level_field == LEVEL_RESET ||
        energy_level_field <= LEVEL_MAX)
        else $error("energy level out of range");

    // Manual measurement runs the full 128 us window
    a_ed_window: assert property (
        (state == ST_ED && m.done) |-> ed_cyc == 12'(ED_LONG_CYC))
        else $error("manual measurement length wrong");

    // Write in listen state starts a manual measurement
    a_ed_start: assert property (
        (idle_st && wr_level && rx_listen && !m.busy && !shr_detect)
        |=> state == ST_ED ##1 m.busy)
        else $error("energy write did not start measurement");

    // Manual measurement end reports and stores its result
    a_ed_report: assert property (
        (state == ST_ED && m.done)
        |=> measure_done_event && energy_level_field == $past(m.level))
        else $error("manual measurement end not reported");

    // Request clears both flags on the next edge
    a_req_clear: assert property (
        (cca_req && state != ST_FIN)
        |=> !assess_complete_flag && !channel_idle_flag)
        else $error("request did not clear flags");

    // Rejected request still completes two edges later, busy
    a_reject_done: assert property (
        (idle_st && cca_req && !(basic_mode && in_rx))
        |=> ##1 assess_complete_flag && !channel_idle_flag &&
        measure_done_event)
        else $error("rejected request not completed");

    // Result available within 180 us of the request
    a_cca_deadline: assert property (
        state == ST_FIN |-> cca_age <= 12'(CCA_MAX_CYC))
        else $error("assessment took too long");

    // Idle only with complete
    a_idle_done: assert property (
        channel_idle_flag |-> assess_complete_flag)
        else $error("idle flag without complete flag");

    // Energy method with level above threshold reports busy
    a_energy_busy: assert property (
        (state == ST_FIN && assess_method_select == M_ENERGY &&
         e_busy) |=> !channel_idle_flag)
        else $error("energy above threshold reported idle");

    // Carrier-only request during a frame answers without waiting
    a_cs_now: assert property (
        (idle_st && cca_req && basic_mode && rx_busy && !rx_listen &&
         reg_wdata[MODE_LSB+1:MODE_LSB] == M_CS_ONLY) |=> state == ST_FIN)
        else $error("carrier-only request waited");

    // Preamble inside a frame already under way starts nothing
    a_auto_once: assert property (
        (shr_detect && rx_busy && $past(rx_busy)) |-> !auto_go)
        else $error("second automatic measurement in frame");

    // Done event is a single-cycle pulse
    a_done_pulse: assert property (
        measure_done_event |=> !measure_done_event)
        else $error("done event longer than one cycle");

    c_ed_done: cover property (state == ST_ED && m.done);
    c_cca_idle: cover property (state == ST_FIN ##1 channel_idle_flag);
    c_cca_wait: cover property (state == ST_WAIT ##1 state == ST_FIN);
    c_auto_short: cover property (auto_go && high_rate);
    c_cca_reject: cover property (idle_st && cca_req && !cca_ok);

endmodule : edc_energy_detect_cca
`default_nettype wire

// >>> test/edc_rx_model.sv
// Receive path model: power samples, carrier sense and frame detection
`timescale 1ns/1ps
`default_nettype none
module edc_rx_model
(
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    // Stimulus knobs
    input  wire logic [4:0] power_set,
    input  wire logic       carrier_set,
    input  wire logic       rx_on,
    input  wire logic       frame_go,
    input  wire logic       frame_end,
    input  wire logic       preamble_detect_disable,
    // Receive path indications
    output logic            rx_listen,
    output logic            rx_busy,
    output logic            shr_detect,
    output logic            carrier_sense,
    output logic [4:0]      rssi
);
    logic [5:0] tick;

    // Listen only while receiving and no frame is under way
    assign rx_listen = rx_on && !rx_busy;

    // Power refreshed every 2 us; frames start only if detection is on
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            tick          <= 6'h00;
            rssi          <= 5'h00;
            rx_busy       <= 1'b0;
            shr_detect    <= 1'b0;
            carrier_sense <= 1'b0;
        end
        else
        begin
            tick          <= (tick == 6'h27) ? 6'h00 : tick + 6'h01;
            rssi          <= (tick == 6'h27) ? power_set : rssi;
            carrier_sense <= carrier_set;
            shr_detect    <= frame_go && !preamble_detect_disable;
            rx_busy       <= frame_end ? 1'b0
                           : (frame_go && !preamble_detect_disable) | rx_busy;
        end
    end
endmodule : edc_rx_model
`default_nettype wire

// >>> test/test_energy_detect_cca_unit.sv
// Self-checking bench for the energy detect and assessment unit
`timescale 1ns/1ps
`default_nettype none
module test_energy_detect_cca_unit;
    import edc_pkg::*;
    logic       sys_clk = 1'b0;
    logic       resetn = 1'b0;
    logic       reg_wr = 1'b0;
    logic [5:0] reg_addr = 6'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic       basic_mode = 1'b1;
    logic       high_rate = 1'b0;
    logic [4:0] power_set = 5'h00;
    logic       carrier_set = 1'b0;
    logic       rx_on = 1'b1;
    logic       frame_go = 1'b0;
    logic       frame_end = 1'b0;
    logic       pdt_off = 1'b1;
    wire logic  rx_listen, rx_busy, shr_detect, carrier_sense;
    wire logic [4:0] rssi;
    wire logic [7:0] level;
    wire logic  complete, idle, done;
    wire edc_method_type method;
    wire logic [THR_W-1:0] thr;
    int fail_count = 0;
    int num_checks = 0;
    int done_seen = 0;
    int n;

    always #25 sys_clk = ~sys_clk;

    // Count every completion pulse seen
    always @(posedge sys_clk)
        if (done === 1'b1) done_seen++;

    edc_rx_model u_rx (.sys_clk(sys_clk), .resetn(resetn),
        .power_set(power_set), .carrier_set(carrier_set), .rx_on(rx_on),
        .frame_go(frame_go), .frame_end(frame_end),
        .preamble_detect_disable(pdt_off), .rx_listen(rx_listen),
        .rx_busy(rx_busy), .shr_detect(shr_detect),
        .carrier_sense(carrier_sense), .rssi(rssi));

    edc_energy_detect_cca u_dut (.sys_clk(sys_clk), .resetn(resetn),
        .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .rx_listen(rx_listen), .rx_busy(rx_busy), .basic_mode(basic_mode),
        .high_rate(high_rate), .shr_detect(shr_detect),
        .carrier_sense(carrier_sense), .rssi(rssi),
        .energy_level_field(level), .assess_complete_flag(complete),
        .channel_idle_flag(idle), .assess_method_select(method),
        .energy_threshold_field(thr), .measure_done_event(done));

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : finish_test

    task automatic check(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1)
        begin
            fail_count++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask : check

    // One write strobe; a clock passes first so strobes never merge
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #1;
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(posedge sys_clk);
        #1 reg_wr = 1'b0;
    endtask : wr

    // Edges until the done pulse is seen, bounded
    task automatic wait_done(input int lim);
        n = 0;
        while (done !== 1'b1 && n < lim)
        begin
            @(posedge sys_clk);
            #1 n++;
        end
        if (done !== 1'b1)
        begin
            fail_count++;
            $display("mismatch at %0t: wait ran out", $time);
            finish_test();
        end
    endtask : wait_done

    // Set receive conditions and let the power sample refresh
    task automatic settle(input logic [4:0] p, input logic c);
        power_set   = p;
        carrier_set = c;
        repeat (45) @(posedge sys_clk);
        #1;
    endtask : settle

    task automatic t_regs();
        check(level === 8'hFF && complete === 1'b0 && idle === 1'b0,
              "reset flags");
        check(method === M_ENERGY && thr === 4'h7 && done === 1'b0,
              "reset config");
        wr(ADDR_THRES, 8'h05);
        wr(6'h3F, 8'hFF);
        wr(ADDR_CCA, 8'h60);
        check(thr === 4'h5 && method === M_CS_AND, "config write");
        check(level === 8'hFF && complete === 1'b0, "no side effect");
        $display("test regs done");
    endtask : t_regs

    task automatic t_ed(input logic [4:0] p, input logic [7:0] exp);
        settle(p, 1'b0);
        wr(ADDR_LEVEL, 8'hA5);
        wait_done(3000);
        check(n === 2561, "manual measure time");
        check(level === exp, "energy level");
        $display("test manual energy done");
    endtask : t_ed

    task automatic t_ed_off();
        rx_on = 1'b0;
        settle(5'h14, 1'b0);
        wr(ADDR_LEVEL, 8'h00);
        wait_done(5);
        check(n === 0 && level === 8'h00, "off receive");
        rx_on = 1'b1;
        $display("test energy off receive done");
    endtask : t_ed_off

    task automatic t_cca(input logic [1:0] m, input logic [4:0] p,
                         input logic c, input logic exp);
        settle(p, c);
        wr(ADDR_CCA, {1'b1, m, 5'h00});
        check(complete === 1'b0 && idle === 1'b0, "flags clear");
        wait_done(CCA_MAX_CYC);
        check(n === 2562 && method === m, "assess time");
        check(complete === 1'b1 && idle === exp, "idle");
    endtask : t_cca

    task automatic t_modes();
        logic c;
        logic e;
        logic b;
        wr(ADDR_THRES, 8'h0F);
        t_cca(M_ENERGY, 5'h0A, 1'b0, 1'b1);
        wr(ADDR_THRES, 8'h0E);
        t_cca(M_ENERGY, 5'h0A, 1'b0, 1'b0);
        for (int m = 0; m < 4; m++)
            for (int k = 0; k < 3; k++)
            begin
                c = (k != 1);
                e = (k != 0);
                b = (m == 1) ? e : (m == 2) ? c : (m == 0) ? (c | e) : (c & e);
                t_cca(m[1:0], e ? 5'h14 : 5'h05, c, !b);
            end
        $display("test methods done");
    endtask : t_modes

    task automatic t_no_basic();
        basic_mode = 1'b0;
        wr(ADDR_CCA, 8'hA0);
        wait_done(5);
        check(n === 1 && complete === 1'b1 && idle === 1'b0,
              "outside basic");
        basic_mode = 1'b1;
        $display("test outside basic done");
    endtask : t_no_basic

    task automatic t_frame();
        int seen;
        pdt_off   = 1'b0;
        high_rate = 1'b1;
        settle(5'h0C, 1'b0);
        seen      = done_seen;
        frame_go  = 1'b1;
        @(posedge sys_clk);
        #1 frame_go = 1'b0;
        n = 0;
        while (level !== 8'h24 && n < 800)
        begin
            @(posedge sys_clk);
            #1 n++;
        end
        check(n > 634 && n < 646, "short auto window");
        if (level !== 8'h24)
            finish_test();
        check(done_seen === seen, "auto without done");
        wr(ADDR_CCA, 8'hC0);
        wait_done(5);
        check(n === 1 && idle === 1'b1, "carrier in frame");
        settle(5'h14, 1'b0);
        frame_go = 1'b1;
        @(posedge sys_clk);
        #1 frame_go = 1'b0;
        repeat (700) @(posedge sys_clk);
        #1 check(level === 8'h24, "one auto per frame");
        frame_end = 1'b1;
        settle(5'h14, 1'b0);
        frame_end = 1'b0;
        frame_go  = 1'b1;
        @(posedge sys_clk);
        #1 frame_go = 1'b0;
        repeat (10) @(posedge sys_clk);
        #1 wr(ADDR_CCA, 8'hA0);
        wait_done(800);
        check(n > 610 && n < 645, "energy waits auto");
        check(level === 8'h3C && idle === 1'b0, "auto result");
        frame_end = 1'b1;
        pdt_off   = 1'b1;
        high_rate = 1'b0;
        @(posedge sys_clk);
        #1 frame_end = 1'b0;
        $display("test frame done");
    endtask : t_frame

    initial
    begin
        repeat (4) @(posedge sys_clk);
        #1 resetn = 1'b1;
        t_regs();
        t_ed(5'h0A, 8'h1E);
        t_ed(5'h1C, 8'h53);
        high_rate = 1'b1;
        t_ed(5'h00, 8'h00);
        high_rate = 1'b0;
        t_ed_off();
        t_modes();
        t_no_basic();
        t_frame();
        finish_test();
    end
endmodule : test_energy_detect_cca_unit
`default_nettype wire
